// ### design/rx_status_pin_driver.sv
/*
 * Drives the receive-valid pin of the parallel port in every interface
 * mode, the receive-error pin in MII/GMII/TBI and the collision pin in
 * MII/GMII/RGMII, and samples the receive-valid pin as a strap while
 * reset is held.
 * Assumes the receive clock edges arrive as one-cycle strobes on clk_in
 * from the clock generator, and pin levels are resolved by the pad ring.
 */
// What this block does
// - Valid pin is a strap in reset, an output after
// - MII/GMII: valid updated on each rising edge
// - MII/GMII: error updated on each rising edge
// - RGMII: control on valid pin, both edges
// - Two-clock TBI: bit 8 on both clocks
// - One-clock TBI: bit 8 on rising edge
// - RTBI: bit 4 rising, bit 9 falling
// - RGMII/RTBI: error pin left undriven
// - Two-clock TBI: bit 9 on both clocks
// - One-clock TBI: bit 9 on rising edge
// - MII/GMII/RGMII: collision pin shows collision
// - Loopback without collision test: collision low
// - Loopback with collision test: test level
// - TBI/RTBI: collision pin left undriven
`timescale 1ns/100ps
module rx_status_pin_driver
    import rx_status_pkg::*;
#(
    parameter int CODE_WIDTH = 10
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Configuration
    input wire logic [2:0] mode_in,
    input wire logic ten_bit_clock_rate_select_in,
    input wire logic loopback_control_bit_in,
    input wire logic collision_test_bit_in,
    // Receive clock edge strobes
    input wire logic rx_rise_in,
    input wire logic rx_fall_in,
    input wire logic even_group_rx_clock_rise_in,
    // Receive path content
    input wire logic rx_valid_in,
    input wire logic rx_error_in,
    input wire logic rx_ctl_rise_in,
    input wire logic rx_ctl_fall_in,
    input wire logic [CODE_WIDTH-1:0] code_group_in,
    input wire logic collision_in,
    input wire logic collision_test_level_in,
    // Receive-valid pin
    input wire logic rx_valid_pin_in,
    output logic rx_valid_pin_out,
    output logic rx_valid_pin_oe_out,
    // Receive-error pin
    output logic rx_error_pin_out,
    output logic rx_error_pin_oe_out,
    // Collision pin
    output logic collision_pin_out,
    output logic collision_pin_oe_out,
    // Captured strap
    output logic strap_two_clock_out
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (CODE_WIDTH < CODE_WIDTH_MIN) begin : g_bad_width
        $error("CODE_WIDTH must hold a ten-bit code group");
    end

    // Mode decode; unknown codes fall back to MII
    function automatic port_mode_t decode_mode(input logic [2:0] code);
        port_mode_t m;
        m = PM_MII;
        if (code == MODE_GMII) begin
            m = PM_GMII;
        end else if (code == MODE_RGMII) begin
            m = PM_RGMII;
        end else if (code == MODE_TBI) begin
            m = PM_TBI;
        end else if (code == MODE_RTBI) begin
            m = PM_RTBI;
        end
        return m;
    endfunction

    // ------------------------------------------------------------
    // Strap synchroniser and capture
    // ------------------------------------------------------------
    logic strap_meta_reg; // First stage, read only by the second
    logic strap_sync_reg; // Second stage
    logic running_reg; // High once reset has been released
    logic strap_reg; // Receive-valid level seen at reset

    // Pin comes from outside, so two flops before use. No reset here:
    // the strap is only present while reset is held, so the chain
    // has to keep sampling the pad right through reset
    always_ff @(posedge clk_in) begin
        strap_meta_reg <= rx_valid_pin_in;
        strap_sync_reg <= strap_meta_reg;
    end

    // Strap is caught by the first clocked edge after release
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            running_reg <= 1'b0;
            strap_reg <= 1'b0;
        end else if (!running_reg) begin
            running_reg <= 1'b1;
            strap_reg <= strap_sync_reg;
        end
    end

    // ------------------------------------------------------------
    // Selection
    // ------------------------------------------------------------
    port_mode_t mode;
    logic two_clock; // Two-clock TBI in force
    logic mode_mii_gmii;
    logic ten_bit; // TBI or RTBI
    logic dv_load; // Receive-valid pin takes a new value
    logic dv_next;
    logic er_load;
    logic er_next;
    logic col_next;
    logic er_drive;
    logic col_drive;
    logic tbi_edge;

    assign mode = decode_mode(mode_in);
    assign two_clock = ten_bit_clock_rate_select_in | strap_reg;
    assign mode_mii_gmii = (mode == PM_MII) || (mode == PM_GMII);
    assign ten_bit = (mode == PM_TBI) || (mode == PM_RTBI);
    // Two-clock TBI also updates on the even-group clock
    assign tbi_edge = rx_rise_in | (two_clock & even_group_rx_clock_rise_in);

    always_comb begin
        dv_load = 1'b0;
        dv_next = rx_valid_pin_out;
        er_load = 1'b0;
        er_next = rx_error_pin_out;
        unique case (mode)
            PM_MII, PM_GMII: begin
                dv_load = rx_rise_in;
                dv_next = rx_valid_in;
                er_load = rx_rise_in;
                er_next = rx_error_in;
            end
            PM_RGMII: begin
                // Rising edge wins should both strobes coincide
                dv_load = rx_rise_in | rx_fall_in;
                dv_next = rx_rise_in ? rx_ctl_rise_in : rx_ctl_fall_in;
            end
            PM_TBI: begin
                dv_load = tbi_edge;
                dv_next = code_group_in[TBI_DV_BIT];
                er_load = tbi_edge;
                er_next = code_group_in[TBI_ER_BIT];
            end
            PM_RTBI: begin
                dv_load = rx_rise_in | rx_fall_in;
                dv_next = rx_rise_in ? code_group_in[RTBI_RISE_BIT]
                                     : code_group_in[RTBI_FALL_BIT];
            end
        endcase
    end

    // Loopback overrides the live collision indication
    assign col_next = loopback_control_bit_in ?
        (collision_test_bit_in & collision_test_level_in)
        : collision_in;
    assign er_drive = mode_mii_gmii || (mode == PM_TBI);
    assign col_drive = !ten_bit;

    // ------------------------------------------------------------
    // Pin registers
    // ------------------------------------------------------------
    // Enables stay low until the strap has been taken, so the pad
    // never fights the pull that sets the strap
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_valid_pin_out <= 1'b0;
            rx_valid_pin_oe_out <= 1'b0;
            rx_error_pin_out <= 1'b0;
            rx_error_pin_oe_out <= 1'b0;
            collision_pin_out <= 1'b0;
            collision_pin_oe_out <= 1'b0;
        end else begin
            if (dv_load) begin
                rx_valid_pin_out <= dv_next;
            end
            if (er_load) begin
                rx_error_pin_out <= er_next;
            end
            collision_pin_out <= col_next;
            rx_valid_pin_oe_out <= running_reg;
            rx_error_pin_oe_out <= running_reg & er_drive;
            collision_pin_oe_out <= running_reg & col_drive;
        end
    end

    assign strap_two_clock_out = strap_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Judged one edge on: at the very first edge the enables are not yet
    // settled by any reset event, but every later edge must see them low
    a_reset_undriven: assert property (@(posedge clk_in)
        !reset_n_in |=> !rx_valid_pin_oe_out && !rx_error_pin_oe_out && !collision_pin_oe_out)
        else $error("pin driven during reset");
    a_valid_driven_after: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        running_reg |=> rx_valid_pin_oe_out)
        else $error("valid pin not driven after reset");
    a_mii_valid_rise: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        mode_mii_gmii && rx_rise_in |=> rx_valid_pin_out == $past(rx_valid_in))
        else $error("mii valid not updated");
    a_mii_error_rise: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        mode_mii_gmii && rx_rise_in |=> rx_error_pin_out == $past(rx_error_in))
        else $error("mii error not updated");
    a_rgmii_ctl_fall: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        mode == PM_RGMII && rx_fall_in && !rx_rise_in
        |=> rx_valid_pin_out == $past(rx_ctl_fall_in))
        else $error("rgmii falling control lost");
    a_tbi_even_clock: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        mode == PM_TBI && two_clock && even_group_rx_clock_rise_in
        |=> rx_valid_pin_out == $past(code_group_in[TBI_DV_BIT])
            && rx_error_pin_out == $past(code_group_in[TBI_ER_BIT]))
        else $error("two-clock tbi missed even clock");
    a_tbi_one_clock: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        mode == PM_TBI && !two_clock && !rx_rise_in |=> $stable(rx_valid_pin_out)
            && $stable(rx_error_pin_out))
        else $error("one-clock tbi updated off edge");
    a_rtbi_rise_bit: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        mode == PM_RTBI && rx_rise_in |=> rx_valid_pin_out == $past(code_group_in[RTBI_RISE_BIT]))
        else $error("rtbi rising bit wrong");
    a_error_hiz: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (mode == PM_RGMII || mode == PM_RTBI) |=> !rx_error_pin_oe_out)
        else $error("error pin driven in rgmii or rtbi");
    a_col_loopback: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        loopback_control_bit_in && !collision_test_bit_in |=> !collision_pin_out)
        else $error("collision not low in loopback");
    a_col_live: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !loopback_control_bit_in |=> collision_pin_out == $past(collision_in))
        else $error("collision does not follow input");
    a_col_test: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        loopback_control_bit_in && collision_test_bit_in
        |=> collision_pin_out == $past(collision_test_level_in))
        else $error("collision test level not shown");
    a_col_hiz: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        ten_bit |=> !collision_pin_oe_out)
        else $error("collision pin driven in ten-bit mode");

endmodule

// ### design/rx_status_pkg.sv
/*
 * Constants shared by the receive status pin driver: mode codes and
 * code-group bit positions.
 * Assumes the mode code is supplied by configuration logic elsewhere.
 */
package rx_status_pkg;

    // ------------------------------------------------------------
    // Parallel port mode codes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_MII = 3'h0;
    localparam logic [2:0] MODE_GMII = 3'h1;
    localparam logic [2:0] MODE_RGMII = 3'h2;
    localparam logic [2:0] MODE_TBI = 3'h3;
    localparam logic [2:0] MODE_RTBI = 3'h4;

    // ------------------------------------------------------------
    // Code-group bit positions carried on the status pins
    // ------------------------------------------------------------
    localparam int TBI_DV_BIT = 8;
    localparam int TBI_ER_BIT = 9;
    localparam int RTBI_RISE_BIT = 4;
    localparam int RTBI_FALL_BIT = 9;
    localparam int CODE_WIDTH_MIN = 10;

    // Decoded mode
    typedef enum logic [2:0] {
        PM_MII,
        PM_GMII,
        PM_RGMII,
        PM_TBI,
        PM_RTBI
    } port_mode_t;

endpackage

// ### sim/rx_status_partner.sv
/*
 * Far-side receiver model: straps the valid pin during reset, resolves
 * the pin level and captures it after each update.
 * Assumes the bench hands it the rising, falling and even-group strobes ORed, whatever the mode.
 */
`timescale 1ns/100ps
module rx_status_partner (
    // Clock, reset and strap
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic strap_in,
    input wire logic strobe_in,
    // Valid pin as the block drives it
    input wire logic valid_out_in,
    input wire logic valid_oe_in,
    // Resolved pin and captured value
    output logic valid_wire_out,
    output logic valid_cap_out
);
    logic strobe_d_reg; // Strobe delayed to the edge after the update
    // Strap only while in reset; board pull-down once released
    assign valid_wire_out = valid_oe_in ? valid_out_in : (!reset_n_in & strap_in);
    // Capture one edge after the load, when the pin has settled
    always_ff @(posedge clk_in) begin
        strobe_d_reg <= strobe_in;
        if (strobe_d_reg) begin
            valid_cap_out <= valid_wire_out;
        end
    end
endmodule

// ### sim/rx_status_pin_driver_bench.sv
/*
 * Self-checking bench for the receive status pin driver, one task per mode, with MII and GMII sharing one.
 * Assumes inputs change on the falling clock edge and outputs lag one edge.
 */
`timescale 1ns/100ps
module rx_status_pin_driver_bench;
    import rx_status_pkg::*;
    logic clk = 0, rst_n = 0, rate = 0, lb = 0, ct = 0, rr = 0, rf = 0, re = 0;
    logic dv = 0, er = 0, cr = 0, cf = 0, col = 0, ctl = 0, strap = 0;
    logic [2:0] mode = MODE_MII;
    logic [9:0] code = 10'h000;
    logic vw, vo, voe, eo, eoe, co, coe, st, cap;
    int bad_count = 0, tests_run = 0;
    // ------------------------------------------------------------
    // Clock, design and far side
    // ------------------------------------------------------------
    initial begin
        forever #10 clk = ~clk;
    end
    rx_status_pin_driver rx_status_pin_driver_i (.clk_in(clk), .reset_n_in(rst_n),
        .mode_in(mode), .ten_bit_clock_rate_select_in(rate), .loopback_control_bit_in(lb),
        .collision_test_bit_in(ct), .rx_rise_in(rr), .rx_fall_in(rf),
        .even_group_rx_clock_rise_in(re), .rx_valid_in(dv), .rx_error_in(er),
        .rx_ctl_rise_in(cr), .rx_ctl_fall_in(cf), .code_group_in(code),
        .collision_in(col), .collision_test_level_in(ctl), .rx_valid_pin_in(vw),
        .rx_valid_pin_out(vo), .rx_valid_pin_oe_out(voe), .rx_error_pin_out(eo),
        .rx_error_pin_oe_out(eoe), .collision_pin_out(co), .collision_pin_oe_out(coe),
        .strap_two_clock_out(st));
    rx_status_partner rx_status_partner_i (.clk_in(clk), .reset_n_in(rst_n),
        .strap_in(strap), .strobe_in(rr | rf | re), .valid_out_in(vo),
        .valid_oe_in(voe), .valid_wire_out(vw), .valid_cap_out(cap));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    // One strobe cycle, then one idle cycle, so that back-to-back calls
    // never lower and raise a strobe in the same time step
    task automatic pulse(input logic r, input logic f, input logic e);
        rr = r; rf = f; re = e;
        @(negedge clk);
        rr = 0; rf = 0; re = 0;
        @(negedge clk);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Called at time zero or on a falling edge; holds reset five cycles
    task automatic do_reset(input logic s);
        rst_n = 0; strap = s;
        repeat (5) @(negedge clk);
        chk(0, voe | eoe | coe);
        rst_n = 1;
        repeat (3) @(negedge clk);
        chk(s, st);
        chk(1, voe);
    endtask
    task automatic t_gmii(input logic [2:0] m);
        mode = m; dv = 0; er = 0; pulse(1, 0, 0);
        dv = 1; er = 1; pulse(0, 1, 1);
        chk(0, vo);
        chk(0, eo);
        pulse(1, 0, 0);
        chk(1, vo);
        chk(1, eo);
        chk(1, eoe);
        @(negedge clk); chk(1, cap);
    endtask
    task automatic t_rgmii;
        mode = MODE_RGMII; cr = 1; cf = 0; pulse(1, 0, 0);
        chk(1, vo);
        pulse(0, 1, 0);
        chk(0, vo);
        @(negedge clk); chk(0, eoe);
        col = 1; @(negedge clk); chk(1, co);
        chk(1, coe);
        col = 0; @(negedge clk); chk(0, co);
    endtask
    task automatic t_tbi(input logic two);
        mode = MODE_TBI; code = 10'h000; pulse(1, 0, 0);
        code = 10'h300; pulse(0, 0, 1);
        chk(two, vo);
        chk(two, eo);
        code = 10'h100; pulse(1, 0, 0);
        chk(1, vo);
        chk(0, eo);
        chk(1, eoe);
        chk(0, coe);
    endtask
    task automatic t_rtbi;
        mode = MODE_RTBI; code = 10'h010; pulse(1, 0, 0);
        chk(1, vo);
        pulse(0, 1, 0);
        chk(0, vo);
        code = 10'h200; pulse(1, 1, 0);
        chk(0, vo);
        pulse(0, 1, 0);
        chk(1, vo);
        chk(0, eoe);
        chk(0, coe);
    endtask
    task automatic t_loop;
        mode = MODE_MII; col = 1; lb = 1; ct = 0;
        repeat (2) @(negedge clk); chk(0, co);
        ct = 1; ctl = 1; @(negedge clk); chk(1, co);
        ctl = 0; @(negedge clk); chk(0, co);
        lb = 0; ct = 0; @(negedge clk); chk(1, co);
        col = 0;
    endtask
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        do_reset(1);
        t_tbi(1);
        t_gmii(MODE_MII);
        t_gmii(MODE_GMII);
        t_gmii(3'h5);
        t_rgmii;
        t_rtbi;
        t_loop;
        do_reset(0);
        t_tbi(0);
        rate = 1; t_tbi(1);
        end_sim;
    end
    // Whole run is about 75 cycles; allow ample margin
    initial begin
        #40000;
        bad_count++;
        end_sim;
    end
endmodule
